// ---- include/shs_consts.svh ----
// offsets, field positions, reset values for the handler state block
`ifndef SHS_CONSTS_SVH
`define SHS_CONSTS_SVH
`define SHS_ADDR_W        4
`define SHS_OFF_STATE     4'h0
`define SHS_OFF_IRQ_STAT  4'h4
`define SHS_OFF_IRQ_MASK  4'h8
`define SHS_RESET_VAL     32'h0000_0000
`define SHS_BIT_MEM_ACT   0
`define SHS_BIT_BUS_ACT   1
`define SHS_BIT_USG_ACT   3
`define SHS_BIT_SVC_ACT   7
`define SHS_BIT_MON_ACT   8
`define SHS_BIT_PSV_ACT   10
`define SHS_BIT_TCK_ACT   11
`define SHS_BIT_USG_PEND  12
`define SHS_BIT_MEM_PEND  13
`define SHS_BIT_BUS_PEND  14
`define SHS_BIT_SVC_PEND  15
`define SHS_BIT_MEM_ENA   16
`define SHS_BIT_BUS_ENA   17
`define SHS_BIT_USG_ENA   18
`define SHS_NUM_FLAGS     11
`define SHS_IRQ_W         4
`endif

// ---- include/shs_pkg.sv ----
// types for the handler state block
package shs_pkg;
  typedef logic [31:0] shs_word_t;
  typedef logic [10:0] shs_flags_t;
  typedef enum logic [1:0] {
    SHS_SEL_NONE  = 2'b00,
    SHS_SEL_STATE = 2'b01,
    SHS_SEL_STAT  = 2'b10,
    SHS_SEL_MASK  = 2'b11
  } shs_sel_e;
endpackage

// ---- src/shs_flag_bit.sv ----
// one flag: core set/clear, software write, set beats clear
`timescale 1ns/1ps
module shs_flag_bit (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_set,
  input  wire logic i_clr,
  input  wire logic i_sw_we,
  input  wire logic i_sw_val,
  output logic      o_q
);
  logic next_q;
  // core set wins over everything, then core clear, then software
  assign next_q = i_set ? 1'b1 :
                  i_clr ? 1'b0 :
                  i_sw_we ? i_sw_val : o_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_q <= 1'b0;
    end else begin
      o_q <= next_q;
    end
  end
endmodule

// ---- src/shs_handler_state.sv ----
// handler active/pending state and fault enable register with irq
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "shs_consts.svh"
module shs_handler_state
  import shs_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_b,
  input  wire logic [`SHS_ADDR_W-1:0] i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  input  wire logic [10:0]            i_flag_set,
  input  wire logic [10:0]            i_flag_clr,
  output logic      [31:0]            o_rdata,
  output logic      [10:0]            o_flags,
  output logic      [2:0]             o_fault_ena,
  output logic                        o_irq
);

  // flag order in the 11-bit vectors: 0 mem act, 1 bus act, 2 usg act,
  // 3 svc act, 4 mon act, 5 psv act, 6 tick act,
  // 7 usg pend, 8 mem pend, 9 bus pend, 10 svc pend
  localparam int FLAG_POS [`SHS_NUM_FLAGS] = '{
    `SHS_BIT_MEM_ACT, `SHS_BIT_BUS_ACT, `SHS_BIT_USG_ACT,
    `SHS_BIT_SVC_ACT, `SHS_BIT_MON_ACT, `SHS_BIT_PSV_ACT,
    `SHS_BIT_TCK_ACT, `SHS_BIT_USG_PEND, `SHS_BIT_MEM_PEND,
    `SHS_BIT_BUS_PEND, `SHS_BIT_SVC_PEND};

  function automatic shs_sel_e addr_sel(
    input logic [`SHS_ADDR_W-1:0] a
  );
    if (a == `SHS_OFF_STATE) begin
      return SHS_SEL_STATE;
    end else if (a == `SHS_OFF_IRQ_STAT) begin
      return SHS_SEL_STAT;
    end else if (a == `SHS_OFF_IRQ_MASK) begin
      return SHS_SEL_MASK;
    end else begin
      return SHS_SEL_NONE;
    end
  endfunction

  function automatic shs_flags_t pick_flags(
    input shs_word_t w
  );
    shs_flags_t f;
    for (int k = 0; k < `SHS_NUM_FLAGS; k++) begin
      f[k] = w[FLAG_POS[k]];
    end
    return f;
  endfunction

  shs_sel_e                 sel;
  wire logic                wr_state;
  wire logic                wr_mask;
  wire logic                rd_stat;
  wire logic                rd_state;
  shs_flags_t               flag_q;
  logic [2:0]               ena;
  logic [`SHS_IRQ_W-1:0]    irq_stat;
  logic [`SHS_IRQ_W-1:0]    irq_mask;
  shs_word_t                state_word;
  shs_word_t                next_rdata;
  wire logic [`SHS_IRQ_W-1:0] irq_evt;
  logic [`SHS_IRQ_W-1:0]    next_irq_stat;
  logic [2:0]               next_ena;
  shs_flags_t               wr_flags;
  logic [`SHS_IRQ_W-1:0]    next_irq_mask;
  logic                     rst_seen;

  assign sel      = addr_sel(i_addr);
  assign wr_state = i_wr && (sel == SHS_SEL_STATE);
  assign wr_mask  = i_wr && (sel == SHS_SEL_MASK);
  assign rd_stat  = i_rd && (sel == SHS_SEL_STAT);
  assign rd_state = i_rd && (sel == SHS_SEL_STATE);
  assign wr_flags = pick_flags(i_wdata);

  // flags: core set/clear and software writes touch only the flag bit
  genvar g;
  generate
    for (g = 0; g < `SHS_NUM_FLAGS; g++) begin : g_flag
      shs_flag_bit u_flag (
        .i_clk    (i_clk),
        .i_rst_b  (i_rst_b),
        .i_set    (i_flag_set[g]),
        .i_clr    (i_flag_clr[g]),
        .i_sw_we  (wr_state),
        .i_sw_val (wr_flags[g]),
        .o_q      (flag_q[g])
      );
    end
  endgenerate

  assign next_ena = wr_state ? {i_wdata[`SHS_BIT_USG_ENA],
                                i_wdata[`SHS_BIT_BUS_ENA],
                                i_wdata[`SHS_BIT_MEM_ENA]} : ena;

  // assemble readback; unused positions stay zero
  always_comb begin
    state_word = `SHS_RESET_VAL;
    for (int i = 0; i < `SHS_NUM_FLAGS; i++) begin
      state_word[FLAG_POS[i]] = flag_q[i];
    end
    state_word[`SHS_BIT_MEM_ENA] = ena[0];
    state_word[`SHS_BIT_BUS_ENA] = ena[1];
    state_word[`SHS_BIT_USG_ENA] = ena[2];
  end

  // events: any active set, any pending set, mem fault pend while its enable is clear, state word write
  assign irq_evt[0] = |i_flag_set[6:0];
  assign irq_evt[1] = |i_flag_set[10:7];
  assign irq_evt[2] = i_flag_set[8] && !ena[0];
  assign irq_evt[3] = wr_state;

  // set wins over read-clear
  assign next_irq_stat = irq_evt | (rd_stat ? '0 : irq_stat);
  assign next_irq_mask = wr_mask ? i_wdata[`SHS_IRQ_W-1:0] : irq_mask;

  assign next_rdata =
    !i_rd                  ? 32'h0000_0000 :
    (sel == SHS_SEL_STATE) ? state_word :
    (sel == SHS_SEL_STAT)  ? {28'h000_0000, irq_stat} :
    (sel == SHS_SEL_MASK)  ? {28'h000_0000, irq_mask} :
                             32'h0000_0000;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ena <= 3'h0;
    end else begin
      ena <= next_ena;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata     <= 32'h0000_0000;
      o_flags     <= 11'h000;
      o_fault_ena <= 3'h0;
      o_irq       <= 1'b0;
    end else begin
      o_rdata     <= next_rdata;
      o_flags     <= flag_q;
      o_fault_ena <= ena;
      o_irq       <= |(next_irq_stat & next_irq_mask);
    end
  end

  // high while reset is held, guards the reset check below
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_seen <= 1'b1;
    end else begin
      rst_seen <= 1'b0;
    end
  end

  a_ena_write: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_state |=> ena == {$past(i_wdata[18]), $past(i_wdata[17]),
                         $past(i_wdata[16])})
    else $error("fault enable did not take written value");

  a_ena_hold: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !wr_state |=> $stable(ena))
    else $error("fault enable changed without a write");

  a_unused_zero: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (o_rdata[31:19] == 13'h0) && !o_rdata[2] && (o_rdata[6:4] == 3'h0)
    && !o_rdata[9] || $past(sel) != SHS_SEL_STATE)
    else $error("reserved bit read as one");

  a_set_wins: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    i_flag_set[0] |=> flag_q[0])
    else $error("active flag not set by core");

  a_clr_core: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_flag_clr[7] && !i_flag_set[7]) |=> !flag_q[7])
    else $error("pending flag not cleared by core");

  a_sw_write: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (wr_state && i_flag_set == 11'h0 && i_flag_clr == 11'h0)
    |=> flag_q[3] == $past(i_wdata[7]) && flag_q[6] == $past(i_wdata[11]))
    else $error("software write to flag lost");

  a_read_state: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_rd && sel == SHS_SEL_STATE) |=> o_rdata[18:16] == $past(ena))
    else $error("enable readback wrong");

  a_irq_level: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_flag_set[10] && irq_mask[1]) |=> o_irq)
    else $error("pending event did not raise irq");

  a_mem_act_read: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    rd_state |=> o_rdata[`SHS_BIT_MEM_ACT] == $past(flag_q[0]))
    else $error("memory fault active readback wrong");

  a_bus_act_read: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    rd_state |=> o_rdata[`SHS_BIT_BUS_ACT] == $past(flag_q[1]))
    else $error("bus fault active readback wrong");

  a_usg_act_read: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    rd_state |=> o_rdata[`SHS_BIT_USG_ACT] == $past(flag_q[2]))
    else $error("usage fault active readback wrong");

  a_svc_act_read: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    rd_state |=> o_rdata[`SHS_BIT_SVC_ACT] == $past(flag_q[3]))
    else $error("supervisor call active readback wrong");

  a_mon_act_read: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    rd_state |=> o_rdata[`SHS_BIT_MON_ACT] == $past(flag_q[4]))
    else $error("debug monitor active readback wrong");

  a_psv_act_read: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    rd_state |=> o_rdata[`SHS_BIT_PSV_ACT] == $past(flag_q[5]))
    else $error("pendable service active readback wrong");

  a_tck_act_read: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    rd_state |=> o_rdata[`SHS_BIT_TCK_ACT] == $past(flag_q[6]))
    else $error("system tick active readback wrong");

  a_usg_pend_read: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    rd_state |=> o_rdata[`SHS_BIT_USG_PEND] == $past(flag_q[7]))
    else $error("usage fault pending readback wrong");

  a_mem_pend_read: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    rd_state |=> o_rdata[`SHS_BIT_MEM_PEND] == $past(flag_q[8]))
    else $error("memory fault pending readback wrong");

  a_bus_pend_read: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    rd_state |=> o_rdata[`SHS_BIT_BUS_PEND] == $past(flag_q[9]))
    else $error("bus fault pending readback wrong");

  a_svc_pend_read: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    rd_state |=> o_rdata[`SHS_BIT_SVC_PEND] == $past(flag_q[10]))
    else $error("supervisor call pending readback wrong");

  a_set_over_clr: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_flag_set != 11'h000) |=> (flag_q & $past(i_flag_set)) == $past(i_flag_set))
    else $error("core set did not win");

  a_clr_only: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    ((i_flag_clr & ~i_flag_set) != 11'h000)
    |=> (flag_q & $past(i_flag_clr & ~i_flag_set)) == 11'h000)
    else $error("core clear did not clear flag");

  a_sw_write_all: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_state |=> ((flag_q ^ $past(wr_flags))
                  & ~$past(i_flag_set | i_flag_clr)) == 11'h000)
    else $error("software write did not land on flags");

  a_flag_hold: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (!wr_state && i_flag_set == 11'h000 && i_flag_clr == 11'h000)
    |=> $stable(flag_q))
    else $error("flag changed without a cause");

  a_flags_out: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    1'b1 |=> o_flags == $past(flag_q))
    else $error("flag output does not follow flags");

  a_ena_out: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    1'b1 |=> o_fault_ena == $past(ena))
    else $error("enable output does not follow enables");

  a_rdata_idle: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero without a read");

  a_irq_follow: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_irq == |(irq_stat & irq_mask))
    else $error("irq does not match unmasked status");

  a_stat_clear: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (rd_stat && irq_evt == 4'h0) |=> irq_stat == 4'h0)
    else $error("status read did not clear status");

  a_stat_event: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (irq_evt != 4'h0)
    |=> (irq_stat & $past(irq_evt)) == $past(irq_evt))
    else $error("event did not set status");

  a_mask_write: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_mask |=> irq_mask == $past(i_wdata[`SHS_IRQ_W-1:0]))
    else $error("mask did not take written value");

  a_reset_clear: assert property (
    @(posedge i_clk)
    (!i_rst_b && rst_seen) |-> flag_q == 11'h000 && ena == 3'h0
    && o_rdata == 32'h0000_0000 && o_flags == 11'h000
    && o_fault_ena == 3'h0 && !o_irq)
    else $error("state not cleared by reset");

  a_unmapped_write: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && sel != SHS_SEL_STATE && i_flag_set == 11'h000
     && i_flag_clr == 11'h000) |=> $stable(flag_q) && $stable(ena))
    else $error("write outside state word changed state");

endmodule

// ---- test/shs_core_model.sv ----
// core exception entry and return model, one-cycle set/clear pulses
`timescale 1ns/1ps
module shs_core_model (
  input  wire logic        i_clk,
  input  wire logic [10:0] i_set_req,
  input  wire logic [10:0] i_clr_req,
  output logic      [10:0] o_flag_set = '0,
  output logic      [10:0] o_flag_clr = '0
);
  always @(posedge i_clk) begin
    o_flag_set <= i_set_req;
    o_flag_clr <= i_clr_req;
  end
endmodule

// ---- test/testbench.sv ----
// self-checking bench for the handler state register block
`timescale 1ns/1ps
module testbench;
  logic        i_clk = 0, i_rst_b = 0, i_wr = 0, i_rd = 0;
  logic [3:0]  i_addr = '0;
  logic [31:0] i_wdata = '0;
  logic [10:0] set_req = '0, clr_req = '0, fset, fclr, o_flags;
  logic [31:0] o_rdata, ms = '0, mstat = '0, mmask = '0;
  logic [2:0]  o_fault_ena;
  logic        o_irq;
  int          error_cnt = 0, n_compared = 0;
  int          pos[11] = '{0, 1, 3, 7, 8, 10, 11, 12, 13, 14, 15};
  always #5 i_clk = ~i_clk;
  shs_core_model core (.i_clk(i_clk), .i_set_req(set_req),
    .i_clr_req(clr_req), .o_flag_set(fset), .o_flag_clr(fclr));
  shs_handler_state dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_flag_set(fset), .i_flag_clr(fclr), .o_rdata(o_rdata),
    .o_flags(o_flags), .o_fault_ena(o_fault_ena), .o_irq(o_irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic outs();
    logic [10:0] f;
    repeat (2) @(posedge i_clk);
    #1;
    for (int i = 0; i < 11; i++) f[i] = ms[pos[i]];
    chk({21'h0, o_flags}, {21'h0, f});
    chk({29'h0, o_fault_ena}, {29'h0, ms[18:16]});
    chk({31'h0, o_irq}, {31'h0, |(mstat & mmask)});
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    if (a == 4'h0) begin
      ms = d & 32'h0007_FD8B;
      mstat[3] = 1'b1;
    end
    if (a == 4'h8) mmask = d & 32'h0000_000F;
    outs();
  endtask
  task automatic rd(input logic [3:0] a);
    logic [31:0] e;
    e = (a == 4'h0) ? ms : (a == 4'h4) ? mstat : (a == 4'h8) ? mmask : '0;
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    if (a == 4'h4) mstat = '0;
    #1;
    chk(o_rdata, e);
  endtask
  task automatic cmd(input logic [10:0] s, input logic [10:0] c);
    @(posedge i_clk);
    set_req <= s;
    clr_req <= c;
    @(posedge i_clk);
    set_req <= '0;
    clr_req <= '0;
    for (int i = 0; i < 11; i++)
      if (s[i]) ms[pos[i]] = 1'b1;
      else if (c[i]) ms[pos[i]] = 1'b0;
    if (|s[6:0]) mstat[0] = 1'b1;
    if (|s[10:7]) mstat[1] = 1'b1;
    if (s[8] && !ms[16]) mstat[2] = 1'b1;
    outs();
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h0000_8bd5));
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    outs();
    for (int a = 0; a < 16; a += 4) rd(a[3:0]);
    for (int i = 0; i < 11; i++) begin
      cmd(11'h1 << i, '0);
      rd(4'h0);
      cmd('0, 11'h1 << i);
      rd(4'h0);
    end
    // set and clear together: set wins
    cmd('1, '1);
    rd(4'h0);
    wr(4'hC, '1);
    rd(4'hC);
    wr(4'h4, '1);
    wr(4'h8, 32'h0000_000F);
    rd(4'h8);
    rd(4'h4);
    outs();
    wr(4'h0, 32'h0001_0000);
    cmd(11'h500, '0);
    rd(4'h4);
    wr(4'h8, '0);
    for (int k = 0; k < 12; k++) begin
      wr(4'h0, $urandom);
      rd(4'h0);
    end
    wr(4'h8, 32'h0000_000F);
    // reset again in mid-run: all state back to zero
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    ms = '0;
    mstat = '0;
    mmask = '0;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    outs();
    rd(4'h0);
    rd(4'h4);
    tally_and_finish();
  end
endmodule
